// *** shared/hsc_pkg.sv ***
// Purpose: constants and types for the halt/standby controller
// Assumes: 100 MHz pclk, apb register map at byte addresses
// Notes:   all timing counts derive from printed times
package hsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int IRQ_N         = 8;
  localparam int PORT_W        = 8;
  localparam int ADDR_W        = 8;
  localparam int CNT_W         = 17;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_LSO_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PORT     = 8'h0c;

  // field positions
  localparam int LSO_STOP_BIT  = 0;
  localparam int CTRL_TMR8_LSO = 0;
  localparam int CTRL_WDT_SYS  = 1;
  localparam int ST_HALTED     = 0;
  localparam int ST_READOUT    = 1;
  localparam int ST_LSO_RUN    = 2;
  localparam int ST_OPT_STOP   = 3;

  // synchroniser bits and their reset levels
  localparam int          PIN_RST_N   = 0;
  localparam int          PIN_OPT     = 1;
  localparam logic [1:0]  PIN_RST_VAL = 2'h1;

  // wake-up delay in cpu clocks
  localparam int WAKE_VEC_MIN   = 11;
  localparam int WAKE_VEC_MAX   = 13;
  localparam int WAKE_NEXT_MIN  = 3;
  localparam int WAKE_NEXT_MAX  = 5;
  localparam int WAKE_VEC_CLKS  = 12;
  localparam int WAKE_NEXT_CLKS = 4;

  // configuration byte readout stop time
  localparam int RO_MIN_US_INT  = 277;
  localparam int RO_MIN_US_XTAL = 276;
  localparam int RO_TYP_US      = 544;
  localparam int RO_MAX_US_INT  = 1075;
  localparam int RO_MAX_US_XTAL = 1074;
  localparam int RO_CYCLES      = RO_TYP_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    HSC_READOUT = 2'b00,
    HSC_RUN     = 2'b01,
    HSC_HALT    = 2'b10,
    HSC_WAKE    = 2'b11
  } hsc_state_t;

  typedef struct packed {
    logic tm16;
    logic tmr8;
    logic adc;
    logic lvd;
    logic extint;
    logic poc;
    logic wdt;
  } hsc_periph_t;

  typedef struct packed {
    logic vector;
    logic next_insn;
    logic restart;
  } hsc_wake_t;

  function automatic logic hsc_mapped(input logic [ADDR_W-1:0] a);
    hsc_mapped = (a == ADDR_LSO_MODE) || (a == ADDR_CTRL) ||
                 (a == ADDR_STATUS) || (a == ADDR_PORT);
  endfunction : hsc_mapped
endpackage : hsc_pkg

// *** src/hsc_seq.sv ***
// Purpose: halt / wake / readout sequencer
// Assumes: halt_instr and pending come from logic on clk
// Notes:   all outputs are registered
`timescale 1ns/10ps
module hsc_seq
  import hsc_pkg::*;
#(
  parameter int READOUT_CYCLES = RO_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // cpu side
  input  wire logic       halt_instr,
  input  wire logic       pending,
  input  wire logic       irq_accept,
  input  wire logic       reset_req,
  // status
  output hsc_state_t      state,
  output logic            cpu_run,
  output hsc_wake_t       wake
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  hsc_state_t       next_state;
  hsc_wake_t        next_wake;
  logic             next_cpu_run;
  // vector choice is held for the whole wake wait
  logic             cnt_vec;
  logic             next_cnt_vec;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wake  = '0;
    case (state)
      HSC_READOUT: begin
        if (cnt == '0) begin
          next_state     = HSC_RUN;
          next_wake.restart = 1'b1;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      HSC_RUN: begin
        if (halt_instr) begin
          next_state = HSC_HALT;
          if (pending) begin
            next_state = HSC_WAKE;
            next_cnt   = irq_accept ? CNT_W'(WAKE_VEC_CLKS - 2) : CNT_W'(WAKE_NEXT_CLKS - 2);
          end
        end
      end
      HSC_HALT: begin
        if (pending) begin
          next_state = HSC_WAKE;
          next_cnt   = irq_accept ? CNT_W'(WAKE_VEC_CLKS - 2) : CNT_W'(WAKE_NEXT_CLKS - 2);
        end
      end
      HSC_WAKE: begin
        if (cnt == '0) begin
          next_state = HSC_RUN;
          if (cnt_vec) next_wake.vector = 1'b1;
          else next_wake.next_insn = 1'b1;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: next_state = HSC_READOUT;
    endcase
    if (reset_req) begin
      next_state = HSC_READOUT;
      next_cnt   = CNT_W'(READOUT_CYCLES - 1);
      next_wake  = '0;
    end
    next_cpu_run = (next_state == HSC_RUN);
  end

  always_comb begin
    next_cnt_vec = cnt_vec;
    if (state != HSC_WAKE && next_state == HSC_WAKE) begin
      next_cnt_vec = irq_accept;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= HSC_READOUT;
      cnt     <= CNT_W'(READOUT_CYCLES - 1);
      wake    <= '0;
      cpu_run <= 1'b0;
      cnt_vec <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      wake    <= next_wake;
      cpu_run <= next_cpu_run;
      cnt_vec <= next_cnt_vec;
    end
  end
endmodule : hsc_seq

// *** src/hsc_top.sv ***
// Purpose: halt low-power control with apb registers
// Assumes: cpu and interrupt logic share pclk; pins are asynchronous
// Notes:   apb answers with one access cycle, no extra waits
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - halt is entered only by the cpu halt instruction.
// - an unmasked request pending at halt entry leaves halt at once.
// - cpu clock is gated off in halt; system oscillator keeps running.
// - port output latch holds its value for the whole halt.
// - 16-bit timer, prescaled 8-bit timer, adc, lvd, ext irq run; poc always.
// - low-speed clocked 8-bit timer runs in halt only while that oscillator runs.
// - system-clocked watchdog stops in halt; selection refused when non-stoppable.
// - low-speed watchdog runs in halt if non-stoppable, stops if stoppable.
// - unmasked request ends halt; masked request keeps halt whatever accept says.
// - wake vectors when accept flag is set, else next instruction.
// - vectored wake runs code 11 to 13 clocks after the request.
// - plain wake runs code 3 to 5 clocks after the request.
// - reset ends halt and restarts at the reset vector.
// - reset readout stop with internal clock is 277 us to 1.075 ms.
// - reset readout stop with crystal clock is 276 us to 1.074 ms.
// - accept flag at zero disables interrupt acknowledgment.
// - oscillator stop bit works only when configuration marks it stoppable.
module hsc_top
  import hsc_pkg::*;
#(
  parameter int READOUT_CYCLES = RO_CYCLES
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // cpu and interrupt logic
  input  wire logic              halt_instr,
  input  wire logic              global_irq_accept,
  input  wire logic [IRQ_N-1:0]  irq_req,
  input  wire logic [IRQ_N-1:0]  interrupt_mask_flag,
  output logic                   cpu_clk_en,
  output hsc_wake_t              wake,
  // pins
  input  wire logic              reset_pin_n,
  input  wire logic              opt_lso_stoppable_pin,
  // clock and peripheral control
  output logic                   lso_osc_en,
  output hsc_periph_t            periph,
  output logic      [PORT_W-1:0] port_latch
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  logic [1:0] s1, s2, s3, filt;
  logic [1:0] next_filt;
  logic [1:0] pin_in;
  assign pin_in = {opt_lso_stoppable_pin, reset_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      always_comb begin
        next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= PIN_RST_VAL;
      s2   <= PIN_RST_VAL;
      s3   <= PIN_RST_VAL;
      filt <= PIN_RST_VAL;
    end else begin
      s1   <= pin_in;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  logic reset_req;
  assign reset_req = !filt[PIN_RST_N];

  ////////////////////////////////////////////////////////////////////////////
  // wake detector
  logic [IRQ_N-1:0] unmasked;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      assign unmasked[gi] = irq_req[gi] & ~interrupt_mask_flag[gi];
    end
  endgenerate

  logic pending;
  assign pending = |unmasked;

  hsc_state_t st;
  logic       cpu_run;

  hsc_seq #(
    .READOUT_CYCLES (READOUT_CYCLES)
  ) u_seq (
    .clk        (pclk),
    .rst_n      (presetn),
    .halt_instr (halt_instr),
    .pending    (pending),
    .irq_accept (global_irq_accept),
    .reset_req  (reset_req),
    .state      (st),
    .cpu_run    (cpu_run),
    .wake       (wake)
  );

  assign cpu_clk_en = cpu_run;

  logic halted;
  logic readout;
  assign halted  = (st == HSC_HALT) || (st == HSC_WAKE);
  assign readout = (st == HSC_READOUT);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic lso_stop, tmr8_lso, wdt_sys, opt_stop;
  logic next_lso_stop, next_tmr8_lso, next_wdt_sys, next_opt_stop;
  logic [PORT_W-1:0] next_port;
  logic wr;
  assign wr = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    next_lso_stop = lso_stop;
    next_tmr8_lso = tmr8_lso;
    next_wdt_sys  = wdt_sys;
    next_port     = port_latch;
    next_opt_stop = opt_stop;
    // configuration byte is taken as readout ends
    if (wake.restart) next_opt_stop = filt[PIN_OPT];
    if (wr) begin
      case (paddr)
        ADDR_LSO_MODE: next_lso_stop = pwdata[LSO_STOP_BIT];
        ADDR_CTRL: begin
          next_tmr8_lso = pwdata[CTRL_TMR8_LSO];
          next_wdt_sys  = pwdata[CTRL_WDT_SYS] & opt_stop;
        end
        ADDR_PORT: if (!halted) next_port = pwdata[PORT_W-1:0];
        default: next_port = port_latch;
      endcase
    end
    if (!next_opt_stop) next_wdt_sys = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lso_stop   <= 1'b0;
      tmr8_lso   <= 1'b0;
      wdt_sys    <= 1'b0;
      opt_stop   <= 1'b0;
      port_latch <= '0;
    end else begin
      lso_stop   <= next_lso_stop;
      tmr8_lso   <= next_tmr8_lso;
      wdt_sys    <= next_wdt_sys;
      opt_stop   <= next_opt_stop;
      port_latch <= next_port;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, computed in setup, shown in the access cycle
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        setup;
  logic        lso_run;
  assign setup = psel & ~penable;
  assign lso_run = ~(lso_stop & opt_stop);

  always_comb begin
    next_pready  = setup;
    next_prdata  = '0;
    next_pslverr = setup & (~hsc_mapped(paddr) | (pwrite & (paddr == ADDR_PORT) & halted));
    if (setup & ~pwrite) begin
      case (paddr)
        ADDR_LSO_MODE: next_prdata[LSO_STOP_BIT] = lso_stop;
        ADDR_CTRL: begin
          next_prdata[CTRL_TMR8_LSO] = tmr8_lso;
          next_prdata[CTRL_WDT_SYS]  = wdt_sys;
        end
        ADDR_STATUS: begin
          next_prdata[ST_HALTED]   = halted;
          next_prdata[ST_READOUT]  = readout;
          next_prdata[ST_LSO_RUN]  = lso_run;
          next_prdata[ST_OPT_STOP] = opt_stop;
        end
        ADDR_PORT: next_prdata[PORT_W-1:0] = port_latch;
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gating of peripherals
  hsc_periph_t next_periph;
  logic        next_lso_en;

  always_comb begin
    next_lso_en        = lso_run;
    next_periph.tm16   = ~readout;
    next_periph.adc    = ~readout;
    next_periph.lvd    = ~readout;
    next_periph.extint = ~readout;
    next_periph.poc    = 1'b1;
    next_periph.tmr8   = ~readout & (~tmr8_lso | lso_run);
    if (wdt_sys) begin
      next_periph.wdt = ~readout & ~halted;
    end else begin
      next_periph.wdt = ~readout & lso_run & ~(halted & opt_stop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph     <= '0;
      lso_osc_en <= 1'b0;
    end else begin
      periph     <= next_periph;
      lso_osc_en <= next_lso_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CNT_W-1:0] ro_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ro_len <= '0;
    else if (readout && !reset_req) ro_len <= ro_len + CNT_W'(1);
    else ro_len <= '0;
  end

  halt_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st == HSC_HALT) |-> $past(halt_instr)) else $error("halt without instruction");
  entry_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == HSC_RUN && halt_instr && pending && !reset_req) |=> st == HSC_WAKE)
    else $error("pending request did not end halt");
  clk_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    halted |-> !cpu_clk_en) else $error("cpu clock running in halt");
  port_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halted && $past(halted)) |-> $stable(port_latch)) else $error("port changed in halt");
  periph_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    halted |=> periph.tm16 && periph.adc && periph.lvd && periph.extint && periph.poc)
    else $error("peripheral stopped in halt");
  tmr8_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tmr8_lso && !lso_run) |=> !periph.tmr8) else $error("timer ran without oscillator");
  wdt_sys_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halted && wdt_sys) |=> !periph.wdt) else $error("system watchdog ran in halt");
  wdt_lso_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halted && !wdt_sys && !readout && !opt_stop) |=> periph.wdt)
    else $error("non-stoppable watchdog stopped");
  mask_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == HSC_HALT && !pending && !reset_req) |=> st == HSC_HALT)
    else $error("halt left without unmasked request");
  wake_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == HSC_HALT && pending && global_irq_accept && !reset_req
     ##1 !reset_req [*8] ##1 !reset_req [*3]) |=> wake.vector && cpu_clk_en)
    else $error("vectored wake not after 12 clocks");
  wake_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == HSC_HALT && pending && !global_irq_accept && !reset_req
     ##1 !reset_req [*3]) |=> wake.next_insn && cpu_clk_en)
    else $error("plain wake not after 4 clocks");
  reset_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    reset_req |=> st == HSC_READOUT && !cpu_clk_en) else $error("reset did not end halt");
  ro_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wake.restart) |-> $past(ro_len) == CNT_W'(READOUT_CYCLES - 1))
    else $error("readout length wrong");
  lso_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !opt_stop |=> lso_osc_en) else $error("oscillator stopped while non-stoppable");

  cov_vec_c:  cover property (@(posedge pclk) disable iff (!presetn) wake.vector);
  cov_next_c: cover property (@(posedge pclk) disable iff (!presetn) wake.next_insn);
  cov_rst_c:  cover property (@(posedge pclk) disable iff (!presetn) halted ##1 reset_req);
  cov_err_c:  cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule : hsc_top

// *** tb/hsc_cpu_model.sv ***
// Purpose: cpu core and interrupt flag model facing the halt controller
// Assumes: one pclk domain; controller outputs are registered
// Notes:   a flag clears only on vectored service, as the core acknowledges it
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module hsc_cpu_model
  import hsc_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // from controller
  input  wire logic             cpu_clk_en,
  input  wire hsc_wake_t        wake,
  // to controller
  output logic                  halt_instr,
  output logic                  global_irq_accept,
  output logic      [IRQ_N-1:0] irq_req,
  output logic      [IRQ_N-1:0] interrupt_mask_flag
);
  // a vectored wake drops every request; a plain wake leaves them pending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_instr          <= 1'b0;
      global_irq_accept   <= 1'b0;
      irq_req             <= 8'h00;
      interrupt_mask_flag <= 8'hff;
    end else if (wake.vector) begin
      irq_req <= 8'h00;
    end
  end

  // only a running core can execute the halt instruction
  task automatic exec_halt;
    @(posedge pclk);
    while (cpu_clk_en !== 1'b1) @(posedge pclk);
    halt_instr <= 1'b1;
    @(posedge pclk);
    halt_instr <= 1'b0;
  endtask : exec_halt

  task automatic post(input logic [IRQ_N-1:0] req, input logic [IRQ_N-1:0] msk,
                      input logic acc);
    @(posedge pclk);
    irq_req             <= req;
    interrupt_mask_flag <= msk;
    global_irq_accept   <= acc;
  endtask : post
endmodule : hsc_cpu_model

// *** tb/tb_halt_standby_control.sv ***
// Purpose: self-checking bench for the halt/standby controller
// Assumes: readout shortened to 20 cycles; apb answers without extra waits
// Notes:   wake delays are judged against the documented ranges
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb_halt_standby_control;
  import hsc_pkg::*;
  localparam int RC = 20;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              halt_instr, global_irq_accept, cpu_clk_en, err;
  logic [IRQ_N-1:0]  irq_req, interrupt_mask_flag;
  logic              reset_pin_n, opt_pin, lso_osc_en;
  logic [PORT_W-1:0] port_latch;
  hsc_wake_t         wake, w;
  hsc_periph_t       periph;
  int                num_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  int                n;

  hsc_top #(.READOUT_CYCLES(RC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_instr(halt_instr), .global_irq_accept(global_irq_accept), .irq_req(irq_req),
    .interrupt_mask_flag(interrupt_mask_flag), .cpu_clk_en(cpu_clk_en), .wake(wake),
    .reset_pin_n(reset_pin_n), .opt_lso_stoppable_pin(opt_pin), .lso_osc_en(lso_osc_en),
    .periph(periph), .port_latch(port_latch));

  hsc_cpu_model cpu (
    .pclk(pclk), .presetn(presetn), .cpu_clk_en(cpu_clk_en), .wake(wake),
    .halt_instr(halt_instr), .global_irq_accept(global_irq_accept), .irq_req(irq_req),
    .interrupt_mask_flag(interrupt_mask_flag));

  ////////////////////////////////////////////////////////////////////////////////
  always #5 pclk = ~pclk;

  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rd_chk

  // counts edges until any wake pulse; pulses stand one cycle only
  task automatic wait_wake;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (wake === 3'b000 && n < 200);
    w = wake;
  endtask : wait_wake

  task automatic go_halt;
    cpu.exec_halt();
    repeat (2) @(posedge pclk);
    #1;
    chk("cpu_clk_en halted", cpu_clk_en, 1'b0);
  endtask : go_halt

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; reset_pin_n = 1'b1; opt_pin = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_wake();
    chk("boot readout", n >= RC && n <= RC + 1, 1'b1);
    chk("boot restart", w, 3'b001);
    rd_chk(ADDR_LSO_MODE, 32'h0, "lso mode reset");
    rd_chk(ADDR_CTRL, 32'h0, "ctrl reset");
    rd_chk(ADDR_PORT, 32'h0, "port reset");
    rd_chk(8'h10, 32'h0, "unmapped data");
    chk("unmapped err", err, 1'b1);
    // non-stoppable: stop bit stored but without effect, system-clock watchdog refused
    apb(1'b1, ADDR_LSO_MODE, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_PORT, 32'ha5);
    chk("lso kept", lso_osc_en, 1'b1);
    rd_chk(ADDR_CTRL, 32'h1, "wdt sys refused");
    go_halt();
    chk("periph halt a", periph, 7'h7f);
    apb(1'b1, ADDR_PORT, 32'h5a);
    chk("port write err", err, 1'b1);
    #1;
    chk("port held", port_latch, 8'ha5);
    rd_chk(ADDR_STATUS, 32'h5, "status halted");
    // masked request never wakes, even with acceptance on
    cpu.post(8'h01, 8'h01, 1'b1);
    repeat (20) @(posedge pclk);
    #1;
    chk("masked holds", cpu_clk_en, 1'b0);
    cpu.post(8'h01, 8'h00, 1'b1);
    wait_wake();
    chk("vector delay", n >= 11 && n <= 13, 1'b1);
    chk("vector kind", w, 3'b100);
    go_halt();
    cpu.post(8'h02, 8'h00, 1'b0);
    wait_wake();
    chk("next delay", n >= 3 && n <= 5, 1'b1);
    chk("next kind", w, 3'b010);
    // flag 1 still pending, so halt falls straight through
    cpu.exec_halt();
    wait_wake();
    chk("pending exit", n <= 6, 1'b1);
    chk("pending kind", w, 3'b010);
    cpu.post(8'h00, 8'hff, 1'b0);
    // reset pin in halt, configuration now marks oscillator stoppable
    opt_pin <= 1'b1;
    go_halt();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    rd_chk(ADDR_STATUS, 32'h6, "pin readout");
    chk("pin stopped", cpu_clk_en, 1'b0);
    reset_pin_n <= 1'b1;
    wait_wake();
    chk("pin readout len", n >= RC && n <= RC + 6, 1'b1);
    chk("pin restart", w, 3'b001);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_LSO_MODE, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk("lso stopped", lso_osc_en, 1'b0);
    rd_chk(ADDR_STATUS, 32'h8, "status stoppable");
    go_halt();
    chk("periph halt b", periph, 7'h5e);
    cpu.post(8'h04, 8'h00, 1'b0);
    wait_wake();
    chk("wake b", w, 3'b010);
    cpu.post(8'h00, 8'hff, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_LSO_MODE, 32'h0);
    rd_chk(ADDR_CTRL, 32'h2, "wdt sys allowed");
    go_halt();
    chk("periph halt c", periph, 7'h7e);
    chk("lso running", lso_osc_en, 1'b1);
    cpu.post(8'h80, 8'h00, 1'b1);
    wait_wake();
    chk("wake c", w, 3'b100);
    wrap_up();
  end
endmodule : tb_halt_standby_control
